// [dcf_fifo.v]
// Dual-domain FIFO flag and counter logic with Wishbone control registers
//
// Operation
// - Read data bus out of the FIFO is 18 bits wide.
// - Upper data bits unused below full width; width follows aspect ratio.
// - Unused read bus bits are undefined; consumers must ignore them.
// - Empty-stop high and FIFO empty: read counter holds.
// - Full-stop high and FIFO full: write counter holds.
// - Full flag in write domain blocks writes at once.
// - Full stays high two write edges after a read frees space.
// - Empty flag in read domain blocks reads at once.
// - Empty stays high two read edges after a write adds data.
// - Full compares write address with synchronised read address.
// - Empty compares read address with synchronised write address.
// - Almost-empty rises when stored count reaches its threshold while reading.
// - Almost-full rises when stored count reaches its threshold while writing.
// - Counters run from zero to 16383, then wrap; the RAM address wraps at depth minus one.
// - Empty-stop low lets the read counter run past empty.
`timescale 1ns/100ps
`default_nettype none
`include "dcf_defs.vh"

module dcf_fifo (
    input wire clk_i,
    input wire rst_i,
    input wire wr_en_i,
    input wire [`DCF_DATA_W-1:0] write_data_bus_i,
    input wire rd_en_i,
    output wire [`DCF_DATA_W-1:0] rd_data_o,
    output reg rd_valid_o,
    output wire full_o,
    output wire empty_o,
    output wire almost_full_flag_o,
    output wire almost_empty_flag_o,
    output wire irq_o,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o
);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    function [`DCF_PTR_W-1:0] bin2gray;
        input [`DCF_PTR_W-1:0] b;
        begin
            bin2gray = b ^ (b >> 1);
        end
    endfunction

    function [`DCF_PTR_W-1:0] gray2bin;
        input [`DCF_PTR_W-1:0] g;
        integer i;
        begin
            gray2bin[`DCF_PTR_W-1] = g[`DCF_PTR_W-1];
            for (i = `DCF_PTR_W-2; i >= 0; i = i - 1) begin
                gray2bin[i] = gray2bin[i+1] ^ g[i];
            end
        end
    endfunction

    function [`DCF_PTR_W-1:0] depth_of;
        input [2:0] ar;
        begin
            case (ar)
                `DCF_AR_4KX1: depth_of = 14'h1000;
                `DCF_AR_2KX2: depth_of = 14'h0800;
                `DCF_AR_1KX4: depth_of = 14'h0400;
                `DCF_AR_512X9: depth_of = 14'h0200;
                default: depth_of = 14'h0100;
            endcase
        end
    endfunction

    function [`DCF_DATA_W-1:0] width_mask;
        input [2:0] ar;
        begin
            case (ar)
                `DCF_AR_4KX1: width_mask = 18'h00001;
                `DCF_AR_2KX2: width_mask = 18'h00003;
                `DCF_AR_1KX4: width_mask = 18'h0000F;
                `DCF_AR_512X9: width_mask = 18'h001FF;
                default: width_mask = 18'h3FFFF;
            endcase
        end
    endfunction

    function [`DCF_ADDR_W-1:0] slot_of;
        input [`DCF_PTR_W-1:0] ptr;
        input [`DCF_PTR_W-1:0] msk;
        begin
            slot_of = ptr[`DCF_ADDR_W-1:0] & msk[`DCF_ADDR_W-1:0];
        end
    endfunction

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    reg [2:0] aspect_reg;
    reg empty_stop_reg;
    reg full_stop_reg;
    reg [`DCF_THR_W-1:0] almost_empty_threshold_reg;
    reg [`DCF_THR_W-1:0] almost_full_threshold_reg;
    reg [`DCF_EV_W-1:0] int_stat_reg;
    reg [`DCF_EV_W-1:0] int_mask_reg;

    // ----------------------------------------
    // Pointers and synchronisers
    // ----------------------------------------
    reg [`DCF_PTR_W-1:0] wbin_reg;
    reg [`DCF_PTR_W-1:0] rbin_reg;
    reg [`DCF_PTR_W-1:0] wgray_reg;
    reg [`DCF_PTR_W-1:0] rgray_reg;
    reg [`DCF_PTR_W-1:0] rgray_s1_reg;
    reg [`DCF_PTR_W-1:0] rgray_s2_reg;
    reg [`DCF_PTR_W-1:0] wgray_s1_reg;
    reg [`DCF_PTR_W-1:0] wgray_s2_reg;
    reg [`DCF_EV_W-1:0] flags_d_reg;

    wire [`DCF_PTR_W-1:0] depth;
    wire [`DCF_PTR_W-1:0] mask;
    wire [`DCF_PTR_W-1:0] count_w;
    wire [`DCF_PTR_W-1:0] count_r;
    wire wr_go;
    wire rd_go;
    wire [`DCF_PTR_W-1:0] wbin_next;
    wire [`DCF_PTR_W-1:0] rbin_next;
    wire [`DCF_EV_W-1:0] flags;
    wire [`DCF_EV_W-1:0] events;
    wire [`DCF_DATA_W-1:0] ram_q;

    assign depth = depth_of(aspect_reg);
    assign mask = depth - 14'h0001;

    // ----------------------------------------
    // Flag decisions
    // ----------------------------------------

    // full from write ptr and synchronised read ptr
    assign count_w = wbin_reg - gray2bin(rgray_s2_reg);
    // empty from read ptr and synchronised write ptr
    assign count_r = gray2bin(wgray_s2_reg) - rbin_reg;

    assign full_o = ($signed(count_w) >= $signed(depth));
    assign empty_o = ($signed(count_r) <= $signed(14'h0000));
    // almost full at threshold; drops when below
    assign almost_full_flag_o =
        ($signed(count_w) >= $signed({2'b00, almost_full_threshold_reg}));
    // almost empty at threshold; drops when above
    assign almost_empty_flag_o =
        ($signed(count_r) <= $signed({2'b00, almost_empty_threshold_reg}));

    // Without full-stop a full FIFO overwrites its oldest words
    // full-stop holds write counter when full
    assign wr_go = wr_en_i & ~(full_o & full_stop_reg);
    // empty-stop holds read counter; runs past empty otherwise
    assign rd_go = rd_en_i & ~(empty_o & empty_stop_reg);

    assign wbin_next = wr_go ? wbin_reg + 14'h0001 : wbin_reg;
    assign rbin_next = rd_go ? rbin_reg + 14'h0001 : rbin_reg;

    // ----------------------------------------
    // Pointer and synchroniser registers
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            wbin_reg <= 14'h0000;
            rbin_reg <= 14'h0000;
            wgray_reg <= 14'h0000;
            rgray_reg <= 14'h0000;
            rgray_s1_reg <= 14'h0000;
            rgray_s2_reg <= 14'h0000;
            wgray_s1_reg <= 14'h0000;
            wgray_s2_reg <= 14'h0000;
            rd_valid_o <= 1'b0;
        end else begin
            wbin_reg <= wbin_next;
            rbin_reg <= rbin_next;
            wgray_reg <= bin2gray(wbin_next);
            rgray_reg <= bin2gray(rbin_next);
            // two write edges before read frees full
            rgray_s1_reg <= rgray_reg;
            rgray_s2_reg <= rgray_s1_reg;
            // two read edges before write clears empty
            wgray_s1_reg <= wgray_reg;
            wgray_s2_reg <= wgray_s1_reg;
            rd_valid_o <= rd_go;
        end
    end

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // address wraps at configured depth
    dcf_ram u_ram (
        .clk_i(clk_i),
        .wr_en_i(wr_go),
        .wr_addr_i(slot_of(wbin_reg, mask)),
        .wr_data_i(write_data_bus_i & width_mask(aspect_reg)),
        .rd_en_i(rd_go),
        .rd_addr_i(slot_of(rbin_reg, mask)),
        .rd_data_o(ram_q)
    );

    // 18-bit read bus; upper bits unused, zero in words written at the current or a narrower aspect
    assign rd_data_o = ram_q;

    // ----------------------------------------
    // Interrupt events
    // ----------------------------------------
    assign flags = {almost_empty_flag_o, almost_full_flag_o, empty_o, full_o};
    assign events = flags & ~flags_d_reg;
    assign irq_o = |(int_stat_reg & int_mask_reg);

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    wire wb_req;
    wire wb_wr;
    wire stat_rd;

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr = wb_req & wb_we_i;
    assign stat_rd = wb_req & ~wb_we_i & (wb_adr_i == `DCF_OFS_INT_STAT);

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            aspect_reg <= `DCF_RST_ASPECT;
            empty_stop_reg <= `DCF_RST_EMPTY_STOP;
            full_stop_reg <= `DCF_RST_FULL_STOP;
            almost_empty_threshold_reg <= `DCF_RST_AE_THR;
            almost_full_threshold_reg <= `DCF_RST_AF_THR;
            int_mask_reg <= `DCF_RST_MASK;
            int_stat_reg <= 4'h0;
            // Edge detector starts at the idle flag levels
            flags_d_reg <= `DCF_RST_FLAGS;
        end else begin
            wb_ack_o <= wb_req;
            flags_d_reg <= flags;
            // Set wins over read-clear
            int_stat_reg <= (stat_rd ? 4'h0 : int_stat_reg) | events;
            if (wb_req & ~wb_we_i) begin
                if (wb_adr_i == `DCF_OFS_CTRL) begin
                    wb_dat_o <= {26'h0000000, full_stop_reg, empty_stop_reg,
                                 1'b0, aspect_reg};
                end else if (wb_adr_i == `DCF_OFS_THRESH) begin
                    wb_dat_o <= {4'h0, almost_full_threshold_reg,
                                 4'h0, almost_empty_threshold_reg};
                end else if (wb_adr_i == `DCF_OFS_STATUS) begin
                    wb_dat_o <= {2'b00, count_r, 12'h000, flags};
                end else if (wb_adr_i == `DCF_OFS_INT_STAT) begin
                    wb_dat_o <= {28'h0000000, int_stat_reg};
                end else if (wb_adr_i == `DCF_OFS_INT_MASK) begin
                    wb_dat_o <= {28'h0000000, int_mask_reg};
                end else begin
                    wb_dat_o <= 32'h00000000;
                end
            end
            if (wb_wr) begin
                if (wb_adr_i == `DCF_OFS_CTRL) begin
                    if (wb_sel_i[0]) begin
                        // Pointers keep running; drain the FIFO before a new aspect
                        aspect_reg <= wb_dat_i[`DCF_CTRL_ASPECT_MSB:`DCF_CTRL_ASPECT_LSB];
                        empty_stop_reg <= wb_dat_i[`DCF_CTRL_EMPTY_STOP_BIT];
                        full_stop_reg <= wb_dat_i[`DCF_CTRL_FULL_STOP_BIT];
                    end
                end else if (wb_adr_i == `DCF_OFS_THRESH) begin
                    if (wb_sel_i[0]) begin
                        almost_empty_threshold_reg[7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        almost_empty_threshold_reg[11:8] <= wb_dat_i[11:8];
                    end
                    if (wb_sel_i[2]) begin
                        almost_full_threshold_reg[7:0] <= wb_dat_i[23:16];
                    end
                    if (wb_sel_i[3]) begin
                        almost_full_threshold_reg[11:8] <= wb_dat_i[27:24];
                    end
                end else if (wb_adr_i == `DCF_OFS_INT_MASK) begin
                    if (wb_sel_i[0]) begin
                        int_mask_reg <= wb_dat_i[`DCF_EV_W-1:0];
                    end
                end
            end
        end
    end

endmodule // dcf_fifo
`default_nettype wire

// [dcf_defs.vh]
// Constants of the dual-clock FIFO flag block: offsets, fields, reset values
`ifndef DCF_DEFS_VH
`define DCF_DEFS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DCF_OFS_CTRL 8'h00
`define DCF_OFS_THRESH 8'h04
`define DCF_OFS_STATUS 8'h08
`define DCF_OFS_INT_STAT 8'h0C
`define DCF_OFS_INT_MASK 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DCF_CTRL_ASPECT_LSB 0
`define DCF_CTRL_ASPECT_MSB 2
`define DCF_CTRL_EMPTY_STOP_BIT 4
`define DCF_CTRL_FULL_STOP_BIT 5
`define DCF_THR_AE_LSB 0
`define DCF_THR_AE_MSB 11
`define DCF_THR_AF_LSB 16
`define DCF_THR_AF_MSB 27
`define DCF_STAT_CNT_LSB 16
`define DCF_STAT_CNT_MSB 29
`define DCF_EV_FULL 0
`define DCF_EV_EMPTY 1
`define DCF_EV_ALMOST_FULL_FLAG 2
`define DCF_EV_ALMOST_EMPTY_FLAG 3

// ----------------------------------------
// Aspect ratio codes
// ----------------------------------------
`define DCF_AR_4KX1 3'h0
`define DCF_AR_2KX2 3'h1
`define DCF_AR_1KX4 3'h2
`define DCF_AR_512X9 3'h3
`define DCF_AR_256X18 3'h4

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define DCF_DATA_W 18
`define DCF_ADDR_W 12
`define DCF_PTR_W 14
`define DCF_THR_W 12
`define DCF_EV_W 4
`define DCF_RST_ASPECT 3'h4
`define DCF_RST_EMPTY_STOP 1'b1
`define DCF_RST_FULL_STOP 1'b1
`define DCF_RST_AE_THR 12'h004
`define DCF_RST_AF_THR 12'h0FC
`define DCF_RST_MASK 4'h0
`define DCF_RST_FLAGS 4'hA

`endif

// [dcf_ram.v]
// Storage array of the FIFO with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "dcf_defs.vh"

module dcf_ram (
    input wire clk_i,
    input wire wr_en_i,
    input wire [`DCF_ADDR_W-1:0] wr_addr_i,
    input wire [`DCF_DATA_W-1:0] wr_data_i,
    input wire rd_en_i,
    input wire [`DCF_ADDR_W-1:0] rd_addr_i,
    output reg [`DCF_DATA_W-1:0] rd_data_o
);

    reg [`DCF_DATA_W-1:0] mem [0:(1<<`DCF_ADDR_W)-1];

    initial begin
        rd_data_o = {`DCF_DATA_W{1'b0}};
    end

    always @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        if (rd_en_i) begin
            rd_data_o <= mem[rd_addr_i];
        end
    end

endmodule // dcf_ram
`default_nettype wire

// [dcf_fifo_properties.sv]
// Checker watching the ports of the FIFO flag block
`timescale 1ns/100ps
`default_nettype none
module dcf_fifo_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic rd_valid_o,
    input wire logic full_o,
    input wire logic empty_o,
    input wire logic almost_full_flag_o,
    input wire logic almost_empty_flag_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_empty_lag: assert property (
        empty_o && wr_en_i && !$past(wr_en_i) && !$past(wr_en_i, 2) |=> empty_o [*2])
        else $error("empty dropped early");
    a_full_lag: assert property (
        full_o && rd_en_i && !$past(rd_en_i) && !$past(rd_en_i, 2) |=> full_o [*2])
        else $error("full dropped early");
    a_empty_stays: assert property (
        empty_o && !wr_en_i && !$past(wr_en_i) && !$past(wr_en_i, 2) |=> empty_o)
        else $error("empty fell without write");
    a_full_stays: assert property (
        full_o && !rd_en_i && !$past(rd_en_i) && !$past(rd_en_i, 2) |=> full_o)
        else $error("full fell without read");
    a_almost_full_flag_write: assert property ($rose(almost_full_flag_o) |-> $past(wr_en_i))
        else $error("almost full rose without write");
    a_almost_empty_flag_read: assert property ($rose(almost_empty_flag_o) |-> $past(rd_en_i))
        else $error("almost empty rose without read");
    a_empty_implies: assert property (empty_o |-> almost_empty_flag_o)
        else $error("empty without almost empty");
    a_read_answer: assert property (rd_en_i && !empty_o |=> rd_valid_o)
        else $error("read not answered");
    a_valid_cause: assert property (rd_valid_o |-> $past(rd_en_i))
        else $error("valid without read");
    c_full: cover property (full_o);
    c_empty_fall: cover property ($fell(empty_o));
    c_almost_full_flag: cover property ($rose(almost_full_flag_o));
endmodule // dcf_fifo_properties
bind dcf_fifo dcf_fifo_properties u_chk (.clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i), .rd_valid_o(rd_valid_o), .full_o(full_o), .empty_o(empty_o),
    .almost_full_flag_o(almost_full_flag_o), .almost_empty_flag_o(almost_empty_flag_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

// [dcf_user.sv]
// User-side model that writes and reads the FIFO
`timescale 1ns/100ps
`default_nettype none
module dcf_user (
    input wire logic clk_i,
    input wire logic [17:0] rd_data_i,
    input wire logic rd_valid_i,
    output logic wr_en_o = 1'b0,
    output logic [17:0] wr_data_o = 18'h00000,
    output logic rd_en_o = 1'b0,
    output int bad_o = 0,
    output int got_o = 0
);
    logic [17:0] q[$];
    logic [17:0] nxt = 18'h00001;
    // Writes n words; keep low leaves the words out of the compare queue
    task automatic push(input int n, input bit keep);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            wr_en_o <= 1'b1;
            wr_data_o <= nxt;
            if (keep)
                q.push_back(nxt);
            nxt = nxt + 18'h15A5B;
        end
        @(posedge clk_i);
        wr_en_o <= 1'b0;
        wr_data_o <= ~nxt;
    endtask
    // Reads n words, idling gap cycles after each to stall
    task automatic pop(input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            rd_en_o <= 1'b1;
            repeat (gap) begin
                @(posedge clk_i);
                rd_en_o <= 1'b0;
            end
        end
        @(posedge clk_i);
        rd_en_o <= 1'b0;
    endtask
    // Compares each returned word with the oldest queued word while the queue holds one
    always @(posedge clk_i) begin
        if (rd_valid_i === 1'b1) begin
            got_o <= got_o + 1;
            if (q.size() > 0 && rd_data_i !== q.pop_front())
                bad_o <= bad_o + 1;
        end
    end
endmodule // dcf_user
`default_nettype wire

// [dcf_fifo_tb.sv]
// Self-checking bench for the FIFO flag block
`timescale 1ns/100ps
`default_nettype none
module dcf_fifo_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic [17:0] wd;
    logic [17:0] rd;
    logic wr_en, rd_en, rv, full, empty, af, ae, irq, ack;
    logic [3:0] fl;
    int errors = 0;
    int n_tests = 0;
    int bad, got;
    assign fl = {full, empty, af, ae};
    always #12.5 clk_i = ~clk_i;
    dcf_fifo DUT (.clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en), .write_data_bus_i(wd),
        .rd_en_i(rd_en), .rd_data_o(rd), .rd_valid_o(rv), .full_o(full), .empty_o(empty),
        .almost_full_flag_o(af), .almost_empty_flag_o(ae), .irq_o(irq), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack));
    dcf_user U (.clk_i(clk_i), .rd_data_i(rd), .rd_valid_i(rv), .wr_en_o(wr_en),
        .wr_data_o(wd), .rd_en_o(rd_en), .bad_o(bad), .got_o(got));
    task automatic close_out();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("FAIL %s exp %h got %h", s, e, g);
            errors++;
        end
    endtask
    task automatic ck(input string s, input logic [3:0] e);
        @(negedge clk_i);
        chk(s, {28'h0, e}, {28'h0, fl});
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 20 && ack !== 1'b1; i++)
            @(posedge clk_i);
        rdat = dat_o;
        cyc <= 1'b0;
        if (i == 20) begin
            errors++;
            close_out();
        end
    endtask
    task automatic t_reset();
        ck("reset flags", 4'h5);
        wb(0, 8'h00, 0);
        chk("ctrl", 32'h34, rdat);
        wb(0, 8'h04, 0);
        chk("thresh", 32'h00FC0004, rdat);
        wb(0, 8'h08, 0);
        chk("status reset", 32'h0000000A, rdat);
        wb(0, 8'h0C, 0);
        chk("no reset events", 0, rdat);
        wb(1, 8'h20, 32'hFFFF);
        wb(0, 8'h20, 0);
        chk("unmapped", 0, rdat);
    endtask
    task automatic t_single();
        U.push(1, 1);
        ck("empty e1", 4'h5);
        ck("empty e2", 4'h5);
        ck("empty e3", 4'h1);
        wb(0, 8'h08, 0);
        chk("status count", 32'h00010008, rdat);
        U.pop(1, 0);
        ck("empty again", 4'h5);
    endtask
    task automatic t_fill();
        U.push(251, 1);
        ck("below af", 4'h0);
        U.push(1, 1);
        ck("at af", 4'h2);
        U.push(4, 1);
        ck("full", 4'hA);
        U.push(1, 0);
        ck("full held", 4'hA);
        U.pop(1, 0);
        ck("full e1", 4'hA);
        ck("full e2", 4'hA);
        ck("full e3", 4'h2);
        U.pop(250, 1);
        ck("above ae", 4'h0);
        U.pop(1, 0);
        ck("at ae", 4'h1);
        U.pop(4, 0);
        ck("drained", 4'h5);
        U.pop(1, 0);
        repeat (2) @(negedge clk_i);
        chk("reads", 257, got);
    endtask
    task automatic t_irq();
        chk("irq masked", 0, irq);
        wb(1, 8'h10, 32'h1);
        @(negedge clk_i);
        chk("irq", 1, irq);
        wb(0, 8'h10, 0);
        chk("mask", 32'h1, rdat);
        wb(0, 8'h0C, 0);
        chk("events", 32'hF, rdat);
        @(negedge clk_i);
        chk("irq clear", 0, irq);
    endtask
    task automatic t_replay();
        wb(1, 8'h00, 32'h24);
        U.pop(1, 0);
        repeat (2) @(negedge clk_i);
        chk("replay", 258, got);
    endtask
    task automatic t_narrow();
        logic [17:0] e;
        wb(1, 8'h00, 32'h33);
        e = U.nxt + 18'h15A5B;
        U.push(2, 0);
        repeat (3) @(negedge clk_i);
        U.pop(1, 0);
        repeat (2) @(negedge clk_i);
        chk("narrow data", {23'h0, e[8:0]}, {23'h0, rd[8:0]});
        chk("narrow reads", 259, got);
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_single();
        t_fill();
        t_irq();
        t_replay();
        t_narrow();
        chk("data", 0, bad);
        close_out();
    end
endmodule // dcf_fifo_tb
`default_nettype wire
